// ==== design/smp_fifo.sv ====
`timescale 1ns/100ps
module smp_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic             doPush;
  logic             doPop;

  // Honest flags: full refuses the writer, empty hides data from the reader
  assign inReady  = (count != FULL_CNT);
  assign outValid = (count != '0);
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign outData  = mem[rdPtr];

  // Storage
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == LAST_PTR) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == LAST_PTR) ? '0 : rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : smp_fifo

// ==== design/smp_lane.sv ====
`timescale 1ns/100ps
module smp_lane (
  input wire logic clk,
  input wire logic reset,
  smp_lane_if.lane bus
);
  import smp_pkg::*;

  localparam logic [3:0] SEG_LAST = 4'(SEG_BITS - 1);

  logic [8:0] txShift;
  logic       rxPick;

  assign rxPick = bus.rxSeg[bus.bitIdx];

  // Transmit bits land at their segment position; the word closes on the last bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txShift   <= 9'h000;
      bus.txSeg <= 10'h000;
    end else if (bus.tick) begin
      if (bus.bitIdx == SEG_LAST) begin
        bus.txSeg <= {bus.txBit, txShift};
      end else begin
        txShift[bus.bitIdx[3:0]] <= bus.txBit;
      end
    end
  end

  // Receive bit for the current segment position, held until the next tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus.rxBit <= 1'b0;
    end else if (bus.tick) begin
      bus.rxBit <= rxPick;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  a_tx_last_bit:
    assert property ((bus.tick && bus.bitIdx == SEG_LAST) |=> bus.txSeg[9] == $past(bus.txBit))
    else $error("last transmit bit not captured");
  a_rx_bit_drive:
    assert property (bus.tick |=> bus.rxBit == $past(rxPick))
    else $error("receive bit not driven from segment");

endmodule : smp_lane

// ==== design/smp_lane_if.sv ====
`timescale 1ns/100ps
interface smp_lane_if;
  logic       tick;
  logic [3:0] bitIdx;
  logic       txBit;
  logic [9:0] rxSeg;
  logic       rxBit;
  logic [9:0] txSeg;

  modport lane (input tick, input bitIdx, input txBit, input rxSeg,
                output rxBit, output txSeg);
  modport ctrl (output tick, output bitIdx, output txBit, output rxSeg,
                input rxBit, input txSeg);
endinterface : smp_lane_if

// ==== design/smp_phy_port_ctrl.sv ====
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
module smp_phy_port_ctrl #(
  parameter int PORT_COUNT = 8
) (
  input  wire logic                                      clk,
  input  wire logic                                      reset,
  input  wire logic                                      serialRefClk,
  input  wire logic                                      smiiSync,
  input  wire logic [smp_pkg::MAX_PORTS-1:0]             portSerialTxIn,
  output logic      [smp_pkg::MAX_PORTS-1:0]             portSerialRxOut,
  input  wire logic                                      mgmtIrqNIn,
  output logic                                           mgmtIrqNOut,
  output logic                                           mgmtIrqNOe,
  input  wire logic                                      mgmtDisable,
  input  wire logic [smp_pkg::MAX_PORTS-1:0]             sigDetectModeSel,
  input  wire logic                                      powerDownIn,
  input  wire logic [smp_pkg::MAX_PORTS*smp_pkg::CFG_PINS-1:0] hwConfigPin,
  input  wire logic [smp_pkg::PHY_W-1:0]                 phyBaseAddr,
  input  wire logic [smp_pkg::ADDR_W-1:0]                regAddr,
  input  wire logic [smp_pkg::DATA_W-1:0]                regWrData,
  input  wire logic                                      regWr,
  input  wire logic                                      regRd,
  output logic      [smp_pkg::DATA_W-1:0]                regRdData,
  output logic      [smp_pkg::MAX_PORTS*smp_pkg::SEG_BITS-1:0] txSegData,
  output logic                                           txSegValid,
  input  wire logic                                      txSegReady,
  input  wire logic [smp_pkg::MAX_PORTS*smp_pkg::SEG_BITS-1:0] rxSegData,
  input  wire logic                                      rxSegValid,
  output logic                                           rxSegReady,
  output logic      [smp_pkg::MAX_PORTS-1:0]             portPowerDown,
  output logic      [smp_pkg::MAX_PORTS-1:0]             portFiber,
  output logic      [smp_pkg::MAX_PORTS-1:0]             portSpeed100,
  output logic      [smp_pkg::MAX_PORTS-1:0]             portFullDuplex,
  output logic      [smp_pkg::MAX_PORTS-1:0]             portAutoNeg
);
  import smp_pkg::*;

  localparam int NP     = MAX_PORTS;
  localparam int SEG_W  = NP * SEG_BITS;
  localparam int CFG_W  = NP * CFG_PINS;
  localparam int PIN_W  = 4 + 2 * NP + CFG_W + PHY_W;
  localparam logic [3:0] SEG_LAST = 4'(SYNC_PERIOD - 1);
  localparam logic [3:0] SETTLE_LAST = 4'(PIN_SETTLE_CYC);
  localparam logic [NP-1:0] ALIVE = NP'((1 << PORT_COUNT) - 1);

  // Port index for a phy address, with a hit flag in the top bit
  function automatic logic [3:0] decodePort(input logic [PHY_W-1:0] phy,
                                            input logic [PHY_W-1:0] base);
    logic [PHY_W-1:0] diff;
    diff = phy - base;
    decodePort = {(diff < PHY_W'(PORT_COUNT)), diff[2:0]};
  endfunction : decodePort

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinS1;
  logic [PIN_W-1:0] pinS2;
  logic [PIN_W-1:0] pinS3;
  logic [PIN_W-1:0] pinLvl;

  assign pinRaw = {serialRefClk, smiiSync, mgmtDisable, powerDownIn,
                   portSerialTxIn, sigDetectModeSel, hwConfigPin, phyBaseAddr};

  // Three stages; a level counts only once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinS1  <= '0;
      pinS2  <= '0;
      pinS3  <= '0;
      pinLvl <= '0;
    end else begin
      pinS1 <= pinRaw;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      for (int i = 0; i < PIN_W; i++) begin
        if (pinS2[i] == pinS3[i]) begin
          pinLvl[i] <= pinS3[i];
        end
      end
    end
  end

  logic             refLvl;
  logic             syncLvl;
  logic             mdisLvl;
  logic             pdLvl;
  logic [NP-1:0]    txLvl;
  logic [NP-1:0]    sdLvl;
  logic [CFG_W-1:0] cfgLvl;
  logic [PHY_W-1:0] baseLvl;

  assign {refLvl, syncLvl, mdisLvl, pdLvl, txLvl, sdLvl, cfgLvl, baseLvl} = pinLvl;

  ////////////////////////////////////////////////////////////////////////////
  // Segment framing on the reference clock
  logic       refPrev;
  logic       refRise;
  logic [3:0] bitIdx;
  logic [3:0] curIdx;
  logic       segEnd;
  logic       segEndQ;

  assign refRise = refLvl && !refPrev;
  assign curIdx  = syncLvl ? 4'h0 : bitIdx;
  assign segEnd  = refRise && (curIdx == SEG_LAST);

  // The sync edge carries bit zero itself; otherwise the count wraps every ten bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refPrev <= 1'b0;
      bitIdx  <= 4'h0;
      segEndQ <= 1'b0;
    end else begin
      refPrev <= refLvl;
      segEndQ <= segEnd;
      if (refRise) begin
        if (curIdx == SEG_LAST) begin
          bitIdx <= 4'h0;
        end else begin
          bitIdx <= curIdx + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial lanes; absent ports are not built and read as zero
  logic [SEG_W-1:0] rxHold;
  logic [SEG_W-1:0] txWord;
  smp_lane_if laneIf [NP] ();

  generate
    for (genvar p = 0; p < NP; p++) begin : g_lane
      if (p < PORT_COUNT) begin : g_on
        assign laneIf[p].tick   = refRise;
        assign laneIf[p].bitIdx = curIdx;
        assign laneIf[p].txBit  = txLvl[p];
        assign laneIf[p].rxSeg  = rxHold[p*SEG_BITS +: SEG_BITS];
        assign portSerialRxOut[p] = laneIf[p].rxBit;
        assign txWord[p*SEG_BITS +: SEG_BITS] = laneIf[p].txSeg;
        smp_lane u_lane (
          .clk   (clk),
          .reset (reset),
          .bus   (laneIf[p])
        );
      end else begin : g_off
        assign portSerialRxOut[p] = 1'b0;
        assign txWord[p*SEG_BITS +: SEG_BITS] = '0;
      end
    end
  endgenerate

  // Next receive segment is taken as the current one finishes; idle if none
  assign rxSegReady = segEnd;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxHold <= '0;
    end else if (segEnd) begin
      rxHold <= rxSegValid ? rxSegData : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit segment buffer; a full buffer drops the segment and flags it
  logic fifoInReady;
  logic txOverrun;

  smp_fifo #(
    .WIDTH (SEG_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk      (clk),
    .reset    (reset),
    .inValid  (segEndQ),
    .inReady  (fifoInReady),
    .inData   (txWord),
    .outValid (txSegValid),
    .outReady (txSegReady),
    .outData  (txSegData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start-up: let pins settle, then load defaults once
  smp_state_t state;
  smp_state_t next_state;
  logic [3:0] settleCnt;

  always_comb begin
    case (state)
      ST_WAIT: next_state = (settleCnt == SETTLE_LAST) ? ST_LOAD : ST_WAIT;
      ST_LOAD: next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_WAIT;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= ST_WAIT;
      settleCnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state == ST_WAIT) begin
        settleCnt <= settleCnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode
  logic [3:0]        portHit;
  logic [REGN_W-1:0] regNum;
  logic              accOpen;
  logic              wrHit;
  logic [2:0]        portIdx;

  assign portHit = decodePort(regAddr[ADDR_W-1:REGN_W], baseLvl);
  assign regNum  = regAddr[REGN_W-1:0];
  assign portIdx = portHit[2:0];
  assign accOpen = (state == ST_RUN) && !mdisLvl && portHit[3];
  assign wrHit   = regWr && accOpen;

  // Control bits: pins give aneg, speed and duplex defaults, later writes win; hardware mode follows pins
  logic [NP-1:0] ctrlPd;
  logic [NP-1:0] ctrlAn;
  logic [NP-1:0] ctrlSpd;
  logic [NP-1:0] ctrlDup;
  logic [NP-1:0] irqEn;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlPd  <= {NP{RST_PWRDN}};
      ctrlAn  <= '0;
      ctrlSpd <= '0;
      ctrlDup <= '0;
      irqEn   <= {NP{RST_IRQEN}};
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (state == ST_LOAD || (state == ST_RUN && mdisLvl)) begin
          ctrlAn[p]  <= cfgLvl[p*CFG_PINS + CFG_ANEG_PIN] && ALIVE[p];
          ctrlSpd[p] <= cfgLvl[p*CFG_PINS + CFG_SPEED_PIN] && ALIVE[p];
          ctrlDup[p] <= cfgLvl[p*CFG_PINS + CFG_DUPLEX_PIN] && ALIVE[p];
        end else if (wrHit && portIdx == 3'(p) && regNum == REG_CONTROL) begin
          ctrlAn[p]  <= regWrData[CTL_ANEG_BIT];
          ctrlSpd[p] <= regWrData[CTL_SPEED_BIT];
          ctrlDup[p] <= regWrData[CTL_DUPLEX_BIT];
          ctrlPd[p]  <= regWrData[CTL_PWRDN_BIT];
        end
        if (wrHit && portIdx == 3'(p) && regNum == REG_IRQ_EN) begin
          irqEn[p] <= regWrData[IRQEN_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs and status-change flags
  logic [NP-1:0] fiberPrev;
  logic [NP-1:0] chgPend;
  logic          rdStat;

  assign rdStat = regRd && accOpen && regNum == REG_IRQ_STAT;

  // Mode and power follow pins and bits; a fiber-mode change sets a flag, set beats read-clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      portFiber      <= '0;
      fiberPrev      <= '0;
      chgPend        <= '0;
      portPowerDown  <= '0;
      portSpeed100   <= '0;
      portFullDuplex <= '0;
      portAutoNeg    <= '0;
    end else begin
      portFiber      <= sdLvl & ALIVE;
      fiberPrev      <= portFiber;
      portPowerDown  <= ({NP{pdLvl}} | ctrlPd) & ALIVE;
      portSpeed100   <= ctrlSpd;
      portFullDuplex <= ctrlDup;
      portAutoNeg    <= ctrlAn;
      for (int p = 0; p < NP; p++) begin
        if (portFiber[p] != fiberPrev[p]) begin
          chgPend[p] <= 1'b1;
        end else if (rdStat && portIdx == 3'(p)) begin
          chgPend[p] <= 1'b0;
        end
      end
    end
  end

  // Dropped transmit segment; cleared by a status read on any port
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txOverrun <= 1'b0;
    end else if (segEndQ && !fifoInReady) begin
      txOverrun <= 1'b1;
    end else if (rdStat) begin
      txOverrun <= 1'b0;
    end
  end

  // Open-drain interrupt: enable low means the pin is pulled low
  logic irqAsk;
  assign irqAsk      = |(irqEn & chgPend);
  assign mgmtIrqNOut = 1'b0;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mgmtIrqNOe <= 1'b1;
    end else begin
      mgmtIrqNOe <= !irqAsk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the strobe; refused reads return zero
  logic [DATA_W-1:0] rdImage;

  always_comb begin
    rdImage = '0;
    case (regNum)
      REG_CONTROL: begin
        rdImage[CTL_PWRDN_BIT]  = ctrlPd[portIdx];
        rdImage[CTL_ANEG_BIT]   = ctrlAn[portIdx];
        rdImage[CTL_SPEED_BIT]  = ctrlSpd[portIdx];
        rdImage[CTL_DUPLEX_BIT] = ctrlDup[portIdx];
      end
      REG_MODE:     rdImage[MODE_FIBER_BIT] = portFiber[portIdx];
      REG_IRQ_EN:   rdImage[IRQEN_BIT] = irqEn[portIdx];
      REG_IRQ_STAT: begin
        rdImage[STAT_CHG_BIT] = chgPend[portIdx];
        rdImage[STAT_OVR_BIT] = txOverrun;
      end
      default:      rdImage = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData <= '0;
    end else begin
      regRdData <= (regRd && accOpen) ? rdImage : '0;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  a_sync_align:
    assert property ((refRise && syncLvl) |=> bitIdx == 4'h1)
    else $error("sync did not restart segment count");
  a_seg_wrap:
    assert property ((refRise && !syncLvl && bitIdx == SEG_LAST) |=> bitIdx == 4'h0)
    else $error("segment count did not wrap after ten bits");
  a_irq_pull_low:
    assert property (irqAsk |=> !mgmtIrqNOe && !mgmtIrqNOut)
    else $error("interrupt not pulled low");
  a_irq_release:
    assert property (!irqAsk |=> mgmtIrqNOe)
    else $error("interrupt held without enabled change");
  a_mgmt_ignored:
    assert property ((regRd && mdisLvl) |=> regRdData == '0)
    else $error("read answered while management disabled");
  a_write_ignored:
    assert property ((regWr && mdisLvl && state == ST_RUN) |=> $stable(irqEn))
    else $error("write taken while management disabled");
  a_pin_defaults:
    assert property ((state == ST_LOAD) |=> ctrlAn[0] == $past(cfgLvl[CFG_ANEG_PIN]))
    else $error("defaults not loaded from pins");
  a_write_wins:
    assert property ((wrHit && portIdx == 3'h0 && regNum == REG_CONTROL)
                     |=> ctrlAn[0] == $past(regWrData[CTL_ANEG_BIT]))
    else $error("register write lost to pin level");
  a_fiber_mode:
    assert property ((sdLvl[0] && ALIVE[0]) |=> portFiber[0])
    else $error("fiber mode not forced");
  a_tp_mode:
    assert property (!sdLvl[0] |=> !portFiber[0])
    else $error("twisted-pair mode not forced");
  a_pd_or:
    assert property (((pdLvl || ctrlPd[0]) && ALIVE[0]) |=> portPowerDown[0])
    else $error("power-down pin not honoured");

endmodule : smp_phy_port_ctrl

// ==== design/smp_pkg.sv ====
package smp_pkg;

  // Port population and serial segment framing
  localparam int MAX_PORTS   = 8;
  localparam int SYNC_PERIOD = 10;
  localparam int SEG_BITS    = 10;
  localparam int FIFO_DEPTH  = 8;
  localparam int CFG_PINS    = 3;

  // Register port widths: address is {phy address, register number}
  localparam int PHY_W  = 5;
  localparam int REGN_W = 6;
  localparam int ADDR_W = PHY_W + REGN_W;
  localparam int DATA_W = 16;

  // Register numbers
  localparam logic [REGN_W-1:0] REG_CONTROL  = 6'h00;
  localparam logic [REGN_W-1:0] REG_MODE     = 6'h10;
  localparam logic [REGN_W-1:0] REG_IRQ_EN   = 6'h12;
  localparam logic [REGN_W-1:0] REG_IRQ_STAT = 6'h13;

  // Field positions
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int CTL_PWRDN_BIT  = 11;
  localparam int CTL_ANEG_BIT   = 12;
  localparam int CTL_SPEED_BIT  = 13;
  localparam int MODE_FIBER_BIT = 0;
  localparam int IRQEN_BIT      = 1;
  localparam int STAT_CHG_BIT   = 2;
  localparam int STAT_OVR_BIT   = 3;

  // Configuration pin positions inside each port's group
  localparam int CFG_ANEG_PIN   = 0;
  localparam int CFG_SPEED_PIN  = 1;
  localparam int CFG_DUPLEX_PIN = 2;

  // Reset values
  localparam logic RST_PWRDN = 1'b0;
  localparam logic RST_IRQEN = 1'b0;

  // Timing: pin settling after reset, in ns and in cycles of the 50 MHz clock
  localparam int CLK_FREQ_MHZ  = 50;
  localparam int PIN_SETTLE_NS = 100;
  localparam int PIN_SETTLE_CYC = (PIN_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;

  // Start-up sequence
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } smp_state_t;

endpackage : smp_pkg

// ==== test/smp_mac_model.sv ====
`timescale 1ns/100ps
module smp_mac_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [79:0] txSeg,
  input  wire logic [7:0]  rxBits,
  output logic             serial_ref_clk,
  output logic             sync,
  output logic [7:0]       txBits,
  output logic [79:0]      rxSeg,
  output logic             segDone
);
  logic [2:0]  half;
  logic [3:0]  idx;
  logic [3:0]  nIdx;
  logic [79:0] cur;
  assign nIdx = (idx == 4'h9) ? 4'h0 : idx + 4'h1;
  // Reference slowed far below 125 MHz so the pin filter can follow it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half <= 3'h0;
      serial_ref_clk <= 1'b0;
    end else begin
      half <= half + 3'h1;
      if (half == 3'h7) serial_ref_clk <= ~serial_ref_clk;
    end
  end
  // Data moves on the falling edge, steady at the rising one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx <= 4'h0;
      sync <= 1'b1;
      txBits <= 8'h00;
      cur <= 80'h0;
      rxSeg <= 80'h0;
      segDone <= 1'b0;
    end else begin
      segDone <= 1'b0;
      if (half == 3'h7 && serial_ref_clk) begin
        for (int p = 0; p < 8; p++) begin
          rxSeg[10*p+idx] <= rxBits[p];
          txBits[p] <= (nIdx == 4'h0) ? txSeg[10*p] : cur[10*p+nIdx];
        end
        if (nIdx == 4'h0) cur <= txSeg;
        idx <= nIdx;
        sync <= (nIdx == 4'h0);
        segDone <= (idx == 4'h9);
      end
    end
  end
endmodule : smp_mac_model

// ==== test/smp_phy_port_ctrl_bench.sv ====
`timescale 1ns/100ps
module smp_phy_port_ctrl_bench;
  import smp_pkg::*;
  logic clk, reset, serial_ref_clk, sync, regWr, regRd, txSegReady, rxSegValid, mgmtDisable;
  logic powerDownIn, segDone, irqOut, irqOe, irqPin, txSegValid, rxSegReady;
  logic [7:0]  txBits, rxBits, sigDet, pPd, pFb, pSp, pFd, pAn;
  logic [23:0] cfg, old;
  logic [4:0]  base;
  logic [10:0] regAddr;
  logic [15:0] wd, rdd, v;
  logic [15:0] seed = 16'he3b3;
  logic [79:0] txSeg, macRx, txData, rxData, lastSeg;
  logic [80:0] rxQ[$];
  logic [79:0] txQ[$], dutQ[$];
  int n_mismatch, check_count, cyc, armAge, fill;
  bit armReq, armed;
  assign irqPin = irqOe ? 1'b1 : irqOut; // Pull-up when released
  smp_phy_port_ctrl dut_u (.clk(clk), .reset(reset), .serialRefClk(serial_ref_clk),
    .smiiSync(sync), .portSerialTxIn(txBits), .portSerialRxOut(rxBits),
    .mgmtIrqNIn(irqPin), .mgmtIrqNOut(irqOut), .mgmtIrqNOe(irqOe),
    .mgmtDisable(mgmtDisable), .sigDetectModeSel(sigDet), .powerDownIn(powerDownIn),
    .hwConfigPin(cfg), .phyBaseAddr(base), .regAddr(regAddr), .regWrData(wd),
    .regWr(regWr), .regRd(regRd), .regRdData(rdd), .txSegData(txData),
    .txSegValid(txSegValid), .txSegReady(txSegReady), .rxSegData(rxData),
    .rxSegValid(rxSegValid), .rxSegReady(rxSegReady), .portPowerDown(pPd),
    .portFiber(pFb), .portSpeed100(pSp), .portFullDuplex(pFd), .portAutoNeg(pAn));
  smp_mac_model mac_u (.clk(clk), .reset(reset), .txSeg(txSeg), .rxBits(rxBits),
    .serial_ref_clk(serial_ref_clk), .sync(sync), .txBits(txBits), .rxSeg(macRx), .segDone(segDone));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  function automatic logic [79:0] r80();
    return {rnd(), rnd(), rnd(), rnd(), rnd()};
  endfunction : r80
  function automatic logic [15:0] ctl(input logic [2:0] c);
    return {2'b00, c[1], c[0], 3'b000, c[2], 8'h00};
  endfunction : ctl
  task chk(input logic [79:0] s, input logic [79:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task wr(input int p, input logic [5:0] r, input logic [15:0] d);
    regAddr <= {base + 5'(p), r};
    wd <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : wr
  task rd(input int p, input logic [5:0] r);
    regAddr <= {base + 5'(p), r};
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    v = rdd;
    repeat (5) @(posedge clk);
  endtask : rd
  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 9000) begin
      n_mismatch++;
      close_out();
    end
  end
  // Serial model: queues follow FIFO fill and the one-segment rx delay
  always @(posedge clk) begin
    if (armed) armAge++;
    // The design pops a segment before the model reports its end, so both sides queue
    if (armAge > 30 && txSegValid === 1'b1 && txSegReady) begin
      dutQ.push_back(txData);
      fill--;
    end
    if (rxSegReady === 1'b1) begin
      if (armed) rxQ.push_back({1'b0, rxSegValid ? rxData : 80'h0});
      rxData <= r80();
      rxSegValid <= ^rnd();
    end
    if (segDone) begin
      if (armed) begin
        if (rxQ.size() && !rxQ[0][80]) chk(macRx, rxQ[0][79:0]);
        if (rxQ.size()) void'(rxQ.pop_front());
        if (fill < FIFO_DEPTH) begin
          txQ.push_back(lastSeg);
          fill++;
        end
      end
      if (armReq && !armed) begin
        armed = 1'b1;
        rxQ.push_back({1'b1, 80'h0});
      end
      lastSeg = txSeg;
      txSeg <= r80();
    end
    while (dutQ.size() && txQ.size()) chk(dutQ.pop_front(), txQ.pop_front());
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, regWr, regRd, mgmtDisable, powerDownIn, txSegReady, rxSegValid} = 7'h42;
    {base, regAddr, wd, sigDet, rxData, lastSeg} = '0;
    base = 5'h1c; // Ports 4..7 wrap past address 31
    txSeg = r80();
    cfg = 24'(r80());
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (12) @(posedge clk);
    armReq = 1'b1;
    for (int p = 0; p < 8; p++) begin
      rd(p, REG_CONTROL);
      chk(v, ctl(cfg[3*p+:3]));
      chk({pSp[p], pAn[p], pFd[p]}, {cfg[3*p+1], cfg[3*p], cfg[3*p+2]});
    end
    old = cfg;
    cfg <= ~cfg;
    repeat (10) @(posedge clk);
    rd(0, REG_CONTROL);
    chk(v, ctl(old[2:0]));
    for (int p = 0; p < 8; p++) begin
      chk({pSp[p], pAn[p], pFd[p]}, {old[3*p+1], old[3*p], old[3*p+2]});
      wr(p, REG_CONTROL, ctl(3'(p)));
      rd(p, REG_CONTROL);
      chk({v, pSp[p], pAn[p], pFd[p]}, {ctl(3'(p)), p[1], p[0], p[2]});
    end
    $display("defaults and override done");
    mgmtDisable <= 1'b1;
    repeat (8) @(posedge clk);
    wr(0, REG_IRQ_EN, 16'h0002);
    rd(0, REG_CONTROL);
    chk({v, pSp[5], pAn[5], pFd[5]}, {16'h0, cfg[16], cfg[15], cfg[17]});
    mgmtDisable <= 1'b0;
    repeat (8) @(posedge clk);
    wr(8, REG_IRQ_EN, 16'h0002);
    rd(8, REG_IRQ_EN);
    chk(v, 16'h0);
    rd(0, REG_IRQ_EN);
    chk(v, 16'h0);
    powerDownIn <= 1'b1;
    repeat (8) @(posedge clk);
    chk(pPd, 8'hff);
    powerDownIn <= 1'b0;
    wr(3, REG_CONTROL, 16'h0800);
    repeat (8) @(posedge clk);
    chk(pPd, 8'h08);
    $display("disable and power-down done");
    for (int p = 0; p < 8; p++) wr(p, REG_CONTROL, 16'h2000);
    sigDet <= 8'(rnd());
    repeat (10) @(posedge clk);
    chk(pFb, sigDet);
    for (int p = 0; p < 8; p++) begin
      rd(p, REG_MODE);
      chk(v[MODE_FIBER_BIT], sigDet[p]);
      rd(p, REG_IRQ_STAT);
    end
    for (int e = 1; e >= 0; e--) begin
      wr(2, REG_IRQ_EN, e ? 16'h0002 : 16'h0);
      repeat (4) @(posedge clk);
      chk(irqPin, 1'b1);
      sigDet[2] <= ~sigDet[2];
      repeat (12) @(posedge clk);
      chk(irqPin, !e);
      rd(2, REG_IRQ_STAT);
      repeat (4) @(posedge clk);
      chk({v[STAT_CHG_BIT], irqPin}, 2'b11);
    end
    $display("mode and interrupt done");
    @(posedge clk iff segDone);
    txSegReady <= 1'b0;
    repeat (11) @(posedge clk iff segDone);
    repeat (5) @(posedge clk);
    txSegReady <= 1'b1;
    repeat (20) @(posedge clk);
    chk(txQ.size(), 0);
    rd(0, REG_IRQ_STAT);
    chk(v[STAT_OVR_BIT], 1'b1);
    rd(0, REG_IRQ_STAT);
    chk(v[STAT_OVR_BIT], 1'b0);
    repeat (1600) begin
      @(posedge clk);
      txSegReady <= ^rnd();
    end
    txSegReady <= 1'b1;
    repeat (200) @(posedge clk);
    chk(txQ.size(), 0);
    $display("serial stream done");
    close_out();
  end
endmodule : smp_phy_port_ctrl_bench
